/* File: adcpo_pkg.sv */
// Constants and carrier types for the converter parallel output interface.
package adcpo_pkg;

  // ---------------------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------------------
  localparam int SAMPLE_BITS = 8;
  localparam int FIFO_DEPTH  = 8;
  localparam int SYNC_STAGES = 3;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 8000;
  localparam int CONV_MAX_RATE_KSPS = 42000;
  // Shortest legal conversion clock period, in picoseconds (rounded down).
  localparam int CONV_MIN_PERIOD_PS = 1000000000 / CONV_MAX_RATE_KSPS;
  // Whole system cycles that a legal conversion period always spans (rounded down).
  localparam int CONV_MIN_CYCLES_I  = (CONV_MIN_PERIOD_PS / CLK_PERIOD_PS < 1) ? 1 :
                                      CONV_MIN_PERIOD_PS / CLK_PERIOD_PS;
  localparam int GAP_CNT_BITS       = 4;
  localparam logic [GAP_CNT_BITS-1:0] CONV_MIN_CYCLES = GAP_CNT_BITS'(CONV_MIN_CYCLES_I);
  localparam logic [GAP_CNT_BITS-1:0] GAP_CNT_MAX     = 4'hF;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [SAMPLE_BITS-1:0] SAMPLE_RST = 8'h00;
  localparam logic                   OE_RST     = 1'b0;
  localparam logic                   SLEEP_RST  = 1'b1;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  // Control pins, as seen from outside the clock domain.
  typedef struct packed {
    logic conv_clk;
    logic oe_n;
    logic sleep_request;
  } adcpo_ctl_s;

  localparam adcpo_ctl_s CTL_RST = '{conv_clk: 1'b0, oe_n: 1'b1, sleep_request: 1'b1};

  // Parallel sample word pins: level and drive enable.
  typedef struct packed {
    logic                   oe;
    logic [SAMPLE_BITS-1:0] data;
  } adcpo_word_s;

  typedef enum logic {
    ADCPO_SLEEP,
    ADCPO_RUN
  } adcpo_mode_e;

endpackage : adcpo_pkg

/* File: adcpo_fifo.sv */
// Flip-flop FIFO carrying samples from the sampling edge to the output edge.
`timescale 1ns/1ps
module adcpo_fifo
  import adcpo_pkg::*;
#(
  parameter int WIDTH = SAMPLE_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("adcpo_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_idx_r;
  logic [AW-1:0]    rd_idx_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_idx_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_idx_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r  <= '0;
    end else if (flush) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_idx_r <= wr_idx_r + 1'b1;
      end
      if (pop) begin
        rd_idx_r <= rd_idx_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : adcpo_fifo

/* File: adcpo_core.sv */
// Device-side digital logic of the converter: sampling, output word and sleep.
//
// Overview of operation
// [R1] Sample the analog input on each falling edge of the conversion clock; a full queue drops the new sample instead.
// [R2] Present a new result on the sample word after each conversion clock rise; while the output enable is high the word holds and results stay queued.
// [R3] Drive every sample word bit while the active-low output enable is low.
// [R4] Release every sample word bit while the active-low output enable is high.
// [R5] Sleep request high suspends conversion and enters power-down mode.
// [R6] Sleep request low runs normal conversion.
// [R7] Each result is an unsigned straight binary 8-bit code.
// [R8] Bit zero carries the least significant bit, bit seven the most.
// [R9] The conversion clock must not exceed 42 MSPS.
// [R10] The receiver takes one word per conversion clock cycle after the rise.
`timescale 1ns/1ps
module adcpo_core
  import adcpo_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Control pins from the capture logic
  input  wire logic                   conv_clk,
  input  wire logic                   oe_n,
  input  wire logic                   sleep_request,
  // Digitised front end level
  input  wire logic [SAMPLE_BITS-1:0] analog_input,
  // Parallel sample word pins
  output logic      [SAMPLE_BITS-1:0] sample_word,
  output logic                        sample_word_oe,
  // Status
  output logic                        sleep_active,
  output logic                        conv_overrate
);

  // The queue serves only power-of-two depths of at least two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("adcpo_core: DEPTH must be a power of two of at least 2");
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  adcpo_ctl_s             ctl_s1_r;
  adcpo_ctl_s             ctl_s2_r;
  adcpo_ctl_s             ctl_s3_r;
  adcpo_ctl_s             ctl_lvl_r;
  adcpo_ctl_s             ctl_lvl_nxt;
  adcpo_ctl_s             ctl_agree;
  logic [SAMPLE_BITS-1:0] ain_s1_r;
  logic [SAMPLE_BITS-1:0] ain_s2_r;
  logic [SAMPLE_BITS-1:0] ain_s3_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_s1_r <= CTL_RST;
      ctl_s2_r <= CTL_RST;
      ctl_s3_r <= CTL_RST;
    end else begin
      ctl_s1_r <= '{conv_clk: conv_clk, oe_n: oe_n, sleep_request: sleep_request};
      ctl_s2_r <= ctl_s1_r;
      ctl_s3_r <= ctl_s2_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ain_s1_r <= SAMPLE_RST;
      ain_s2_r <= SAMPLE_RST;
      ain_s3_r <= SAMPLE_RST;
    end else begin
      ain_s1_r <= analog_input;
      ain_s2_r <= ain_s1_r;
      ain_s3_r <= ain_s2_r;
    end
  end

  // A pin level is accepted only once the second and third stages agree.
  assign ctl_agree   = ~(ctl_s2_r ^ ctl_s3_r);
  assign ctl_lvl_nxt = (ctl_s3_r & ctl_agree) | (ctl_lvl_r & ~ctl_agree);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_lvl_r <= CTL_RST;
    end else begin
      ctl_lvl_r <= ctl_lvl_nxt;
    end
  end

  logic conv_fall;
  logic conv_rise;

  assign conv_fall = ctl_lvl_r.conv_clk && !ctl_lvl_nxt.conv_clk;
  assign conv_rise = !ctl_lvl_r.conv_clk && ctl_lvl_nxt.conv_clk;

  // ---------------------------------------------------------------------------
  // Mode control
  // ---------------------------------------------------------------------------
  adcpo_mode_e mode_r;
  adcpo_mode_e mode_nxt;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      ADCPO_SLEEP: begin
        // [R6] Normal operation resumes.
        if (!ctl_lvl_r.sleep_request) begin
          mode_nxt = ADCPO_RUN;
        end
      end
      ADCPO_RUN: begin
        // [R5] Power-down entry.
        if (ctl_lvl_r.sleep_request) begin
          mode_nxt = ADCPO_SLEEP;
        end
      end
      default: begin
        mode_nxt = ADCPO_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= ADCPO_SLEEP;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_active <= SLEEP_RST;
    end else begin
      sleep_active <= (mode_nxt == ADCPO_SLEEP);
    end
  end

  // ---------------------------------------------------------------------------
  // Sample path
  // ---------------------------------------------------------------------------
  logic                   running;
  logic                   take_sample;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [SAMPLE_BITS-1:0] fifo_out_data;
  logic                   drive_on;

  assign running  = (mode_r == ADCPO_RUN);
  assign drive_on = !ctl_lvl_r.oe_n;

  // [R1] Capture on the falling conversion edge.
  // [R7] The code is stored unsigned, straight binary.
  assign take_sample = running && conv_fall;

  // [R2] Release the oldest result on the rising conversion edge while the pins are driven.
  assign fifo_out_ready = running && conv_rise && drive_on;

  // Samples stay queued while the pins are released; a full queue drops new samples.
  adcpo_fifo #(
    .WIDTH (SAMPLE_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (!running),
    .in_valid  (take_sample),
    .in_ready  (fifo_in_ready),
    .in_data   (ain_s3_r),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------------------
  // Output pins
  // ---------------------------------------------------------------------------
  adcpo_word_s word_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_r.data <= SAMPLE_RST;
    end else if (fifo_out_ready && fifo_out_valid) begin
      // [R8] Bit zero is the least significant bit.
      word_r.data <= fifo_out_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_r.oe <= OE_RST;
    end else begin
      // [R3] Drive while enabled.
      // [R4] Release while disabled.
      word_r.oe <= !ctl_lvl_nxt.oe_n;
    end
  end

  assign sample_word    = word_r.data;
  assign sample_word_oe = word_r.oe;

  // ---------------------------------------------------------------------------
  // Conversion rate monitor
  // ---------------------------------------------------------------------------
  logic [GAP_CNT_BITS-1:0] gap_cnt_r;
  logic                    seen_fall_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_cnt_r   <= '0;
      seen_fall_r <= 1'b0;
    end else if (!running) begin
      gap_cnt_r   <= '0;
      seen_fall_r <= 1'b0;
    end else if (conv_fall) begin
      gap_cnt_r   <= '0;
      seen_fall_r <= 1'b1;
    end else if (gap_cnt_r != GAP_CNT_MAX) begin
      gap_cnt_r <= gap_cnt_r + 1'b1;
    end
  end

  // [R9] Flag falling edges fewer than CONV_MIN_CYCLES system cycles apart.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_overrate <= 1'b0;
    end else if (running && conv_fall && seen_fall_r &&
                 gap_cnt_r < (CONV_MIN_CYCLES - 4'h1)) begin
      conv_overrate <= 1'b1;
    end
  end

endmodule : adcpo_core

/* File: adcpo_core_monitor.sv */
// Port checker for the converter parallel output core.
`timescale 1ns/1ps
module adcpo_core_monitor
  import adcpo_pkg::*;
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // Control pins
  input wire logic                   conv_clk,
  input wire logic                   oe_n,
  input wire logic                   sleep_request,
  input wire logic [SAMPLE_BITS-1:0] analog_input,
  // Outputs
  input wire logic [SAMPLE_BITS-1:0] sample_word,
  input wire logic                   sample_word_oe,
  input wire logic                   sleep_active,
  input wire logic                   conv_overrate
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  oe_drive_on_a: assert property (!$past(oe_n, 4) |-> sample_word_oe)
    else $error("word pins not driven while enabled");
  oe_drive_off_a: assert property ($past(oe_n, 4) |-> !sample_word_oe)
    else $error("word pins driven while disabled");
  word_edge_a: assert property ($changed(sample_word) |->
                                $past(conv_clk, 4) && !$past(conv_clk, 5))
    else $error("word changed away from a clock rise");
  word_enable_a: assert property ($changed(sample_word) |->
                                  !$past(oe_n, 5) && !$past(sleep_active))
    else $error("word changed while disabled or asleep");
  sleep_enter_a: assert property (sleep_request [*5] |=> sleep_active)
    else $error("power-down not entered");
  sleep_leave_a: assert property (!sleep_request [*5] |=> !sleep_active)
    else $error("power-down not left");
  sleep_freeze_a: assert property (sleep_active && $past(sleep_active) |-> $stable(sample_word))
    else $error("word changed during power-down");
  overrate_sticky_a: assert property (conv_overrate |=> conv_overrate)
    else $error("overrate flag cleared without reset");
endmodule : adcpo_core_monitor

bind adcpo_core adcpo_core_monitor mon (.clk(clk), .rst(rst), .conv_clk(conv_clk),
  .oe_n(oe_n), .sleep_request(sleep_request), .analog_input(analog_input),
  .sample_word(sample_word), .sample_word_oe(sample_word_oe),
  .sleep_active(sleep_active), .conv_overrate(conv_overrate));

/* File: adcpo_cap.sv */
// Capture logic model: drives conversion clock and controls, takes words.
`timescale 1ns/1ps
module adcpo_cap
  import adcpo_pkg::*;
(
  // Clock
  input  wire logic                   clk,
  // Word pins
  input  wire logic [SAMPLE_BITS-1:0] sample_word,
  input  wire logic                   sample_word_oe,
  // Controls and captured word
  output logic                        conv_clk,
  output logic                        oe_n,
  output logic                        sleep_request,
  output logic      [SAMPLE_BITS-1:0] got
);
  initial begin
    conv_clk      = 1'b1;
    oe_n          = 1'b1;
    sleep_request = 1'b1;
    got           = 8'h00;
  end

  task automatic ctl(input logic oe_off, input logic sleep);
    @(posedge clk);
    oe_n          <= oe_off;
    sleep_request <= sleep;
    repeat (8) @(posedge clk);
  endtask : ctl

  // Legal rate, one word taken per conversion cycle.
  task automatic conv_cycle();
    @(posedge clk);
    conv_clk <= 1'b0;
    repeat (5) @(posedge clk);
    conv_clk <= 1'b1;
    repeat (5) @(posedge clk);
    // A released line shows the inverse of its last level.
    got <= sample_word_oe ? sample_word : ~got;
    @(posedge clk);
  endtask : conv_cycle
endmodule : adcpo_cap

/* File: tb_top.sv */
// Self-checking testbench for the converter parallel output core.
`timescale 1ns/1ps
module tb_top;
  import adcpo_pkg::*;
  logic                   clk;
  logic                   rst;
  logic [SAMPLE_BITS-1:0] analog_input;
  logic [SAMPLE_BITS-1:0] sample_word;
  logic [SAMPLE_BITS-1:0] got;
  logic                   conv_clk;
  logic                   oe_n;
  logic                   sleep_request;
  logic                   sample_word_oe;
  logic                   sleep_active;
  logic                   conv_overrate;
  int                     mismatches = 0;
  int                     n_checks   = 0;
  int                     cycles     = 0;

  adcpo_core #(.DEPTH(FIFO_DEPTH)) dut (.clk(clk), .rst(rst), .conv_clk(conv_clk),
    .oe_n(oe_n), .sleep_request(sleep_request), .analog_input(analog_input),
    .sample_word(sample_word), .sample_word_oe(sample_word_oe),
    .sleep_active(sleep_active), .conv_overrate(conv_overrate));
  adcpo_cap cap (.clk(clk), .sample_word(sample_word), .sample_word_oe(sample_word_oe),
    .conv_clk(conv_clk), .oe_n(oe_n), .sleep_request(sleep_request), .got(got));

  // ---------------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_stream();
    logic [7:0] codes [5] = '{8'h01, 8'h80, 8'hA5, 8'hFF, 8'h00};
    cap.ctl(1'b0, 1'b0);
    check("sleep_active", sleep_active, 8'h00);
    foreach (codes[i]) begin
      @(posedge clk);
      analog_input <= codes[i];
      cap.conv_cycle();
      check("word", got, codes[i]);
      check("oe", sample_word_oe, 8'h01);
    end
  endtask : t_stream

  // Outputs off while eight samples queue and two are dropped, then drain.
  task automatic t_fill();
    logic [7:0] exp;
    cap.ctl(1'b1, 1'b0);
    for (int i = 0; i < 10; i++) begin
      analog_input <= 8'(8'h10 + i);
      cap.conv_cycle();
      check("oe", sample_word_oe, 8'h00);
    end
    cap.ctl(1'b0, 1'b0);
    for (int i = 0; i < 9; i++) begin
      analog_input <= 8'(8'h20 + i);
      cap.conv_cycle();
      exp = (i < 8) ? 8'(8'h10 + i) : 8'h21;
      check("drained word", got, exp);
    end
  endtask : t_fill

  task automatic t_sleep();
    cap.ctl(1'b0, 1'b1);
    check("sleep_active", sleep_active, 8'h01);
    analog_input <= 8'h3C;
    cap.conv_cycle();
    check("word asleep", got, 8'h21);
    cap.ctl(1'b0, 1'b0);
    check("sleep_active", sleep_active, 8'h00);
    cap.conv_cycle();
    check("word awake", got, 8'h3C);
    check("overrate", conv_overrate, 8'h00);
  endtask : t_sleep

  initial begin
    rst          = 1'b1;
    analog_input = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset word", sample_word, 8'h00);
    check("reset oe", sample_word_oe, 8'h00);
    check("reset sleep", sleep_active, 8'h01);
    t_stream();
    t_fill();
    t_sleep();
    tally_and_finish();
  end
endmodule : tb_top
